// ### hw/rtcsr_pkg.sv
// constants and types for the counter control and soft-reset block
`default_nettype none
package rtcsr_pkg;
  localparam logic [11:0] rtcsr_ctrl_off = 12'h000;
  localparam logic [11:0] rtcsr_dbg_off = 12'h004;
  localparam logic [11:0] rtcsr_stat_off = 12'h008;
  localparam logic [11:0] rtcsr_cnt_off = 12'h00C;
  localparam logic [15:0] rtcsr_ctrl_rst = 16'h0000;
  localparam int rtcsr_soft_reset_trigger_bit = 0;
  localparam int rtcsr_en_bit = 1;
  localparam int rtcsr_mode_lo = 2;
  localparam int rtcsr_mode_hi = 3;
  localparam int rtcsr_div_lo = 8;
  localparam int rtcsr_div_hi = 11;
  localparam logic [3:0] rtcsr_div_max = 4'h6;
  localparam logic [2:0] rtcsr_sync_cycles = 3'h3;
  localparam int rtcsr_src_ns = 10;
  localparam int rtcsr_src_per = rtcsr_src_ns / 10;
  typedef enum logic [2:0] {
    rtcsr_idle = 3'b001,
    rtcsr_busy = 3'b010,
    rtcsr_rst = 3'b100
  } rtcsr_state_e;
endpackage : rtcsr_pkg
`default_nettype wire

// ### hw/rtcsr_prescale.sv
// prescaler producing the counter tick from the source clock
`default_nettype none
module rtcsr_prescale (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clr,
  input wire logic [3:0] div_sel,
  output logic tick
);
  import rtcsr_pkg::*;
  logic [5:0] pre_cnt; // free prescale counter
  logic [6:0] span;    // 2^sel_lim, the clamped div_sel
  logic [3:0] sel_lim; // out-of-range codes clamp to /64
  assign sel_lim = (div_sel > rtcsr_div_max) ? rtcsr_div_max : div_sel;
  assign span = 7'h01 << sel_lim;
  always_ff @(posedge core_clk) begin
    if (srst || clr) begin
      pre_cnt <= 6'h00;
      tick <= 1'b0;
    end else begin
      tick <= (7'({1'b0, pre_cnt}) + 7'h01 >= span);
      pre_cnt <= (7'({1'b0, pre_cnt}) + 7'h01 >= span) ? 6'h00 : pre_cnt + 6'h01;
    end
  end
  chk_tick_div1: assert property (@(posedge core_clk) disable iff (srst)
    !clr && div_sel == 4'h0 |=> tick) else $error("divide by one missed a tick");
endmodule : rtcsr_prescale
`default_nettype wire

// ### hw/rtcsr_top.sv
// control register, soft reset and counter core behind apb
`default_nettype none
module rtcsr_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_protect,
  output logic cnt_enabled,
  output logic [1:0] cnt_mode,
  output logic [31:0] cnt_value
);
  import rtcsr_pkg::*;
  // layout of this block, top to bottom:
  // bus decode and read mux, registered apb answer,
  // soft reset sequencer, written control fields,
  // debug register, counter-side copies, counter and prescaler,
  // and last the checks, none of which covers the debug register or the counter
  rtcsr_state_e state; // soft reset sequence state
  logic [2:0] sync_cnt; // sync delay counter
  logic [3:0] div_f;    // divider field, unsynchronized
  logic [1:0] mode_p;   // mode, written side
  logic en_p;           // enable, written side
  logic [7:0] dbg_reg;  // debug control, survives soft reset
  logic sync_pend;      // write sync pending flag
  logic tick;           // counter tick
  // bus decode
  // writes count only in the access phase; the registered answer
  // below then qualifies every register update with pready, so a
  // write lands exactly once, on the edge at which pready stands high
  // a write under wr_protect never reaches any register
  wire access = psel && penable;
  wire wr = access && pwrite && !wr_protect;
  wire wr_ctrl = wr && paddr == rtcsr_ctrl_off;
  wire wr_dbg = wr && paddr == rtcsr_dbg_off;
  wire hit = paddr == rtcsr_ctrl_off || paddr == rtcsr_dbg_off
    || paddr == rtcsr_stat_off || paddr == rtcsr_cnt_off;
  // only a one starts the reset
  wire soft_reset_trigger_req = wr_ctrl && pwdata[rtcsr_soft_reset_trigger_bit];
  wire resetting = state != rtcsr_idle;
  wire fld_wr = wr_ctrl && !pwdata[rtcsr_soft_reset_trigger_bit] && !resetting;
  wire prot_ok = fld_wr && !en_p && !cnt_enabled;
  wire [15:0] ctrl_rd = {4'h0, div_f, 4'h0, mode_p, en_p, resetting};
  wire [31:0] rd_mux = paddr == rtcsr_ctrl_off ? {16'h0000, ctrl_rd} :
    paddr == rtcsr_dbg_off ? {24'h00_0000, dbg_reg} :
    paddr == rtcsr_stat_off ? {31'h0000_0000, sync_pend} :
    paddr == rtcsr_cnt_off ? cnt_value : 32'h0000_0000;
  // apb answer registered: one wait state
  // pready is a single-cycle pulse; the !pready term stops a held
  // access phase from being answered twice
  // read data are captured with the answer and then held
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && (!hit || (pwrite && wr_protect));
      prdata <= (access && !pready && !pwrite) ? rd_mux : prdata;
    end
  end
  // the sequencer models the sync delay into the counter domain;
  // the trigger reads back as one from the start edge until the
  // reset step has ended, so software can poll it without a status read
  // reset sequence with sync delay
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= rtcsr_idle;
      sync_cnt <= 3'h0;
    end else begin
      case (state)
        rtcsr_idle: if (soft_reset_trigger_req && pready) begin
          state <= rtcsr_busy;
          sync_cnt <= 3'h0;
        end
        rtcsr_busy: begin
          sync_cnt <= sync_cnt + 3'h1;
          if (sync_cnt + 3'h1 >= rtcsr_sync_cycles) state <= rtcsr_rst;
        end
        rtcsr_rst: state <= rtcsr_idle;
        default: state <= rtcsr_idle;
      endcase
    end
  end
  // control fields; cleared in reset step, debug kept
  always_ff @(posedge core_clk) begin
    if (srst || state == rtcsr_rst || (soft_reset_trigger_req && pready)) begin
      mode_p <= rtcsr_ctrl_rst[rtcsr_mode_hi:rtcsr_mode_lo];
      en_p <= rtcsr_ctrl_rst[rtcsr_en_bit];
      div_f <= rtcsr_ctrl_rst[rtcsr_div_hi:rtcsr_div_lo];
    end else if (fld_wr && pready) begin
      en_p <= pwdata[rtcsr_en_bit];
      if (prot_ok) div_f <= pwdata[rtcsr_div_hi:rtcsr_div_lo];
      if (prot_ok) mode_p <= pwdata[rtcsr_mode_hi:rtcsr_mode_lo];
    end
  end
  // the debug register sits outside the soft reset on purpose,
  // so a debugger keeps its setting across a software reset
  // debug register only cleared by hard reset
  always_ff @(posedge core_clk) begin
    if (srst) dbg_reg <= 8'h00;
    else if (wr_dbg && pready) dbg_reg <= pwdata[7:0];
  end
  // counter-side copies lag the written fields by one cycle;
  // they are frozen while a soft reset runs, but div_f reaches the
  // prescaler unsynchronized, so the counter runs on the reset divider until the reset step
  // one-stage sync of enable and mode into counter side
  always_ff @(posedge core_clk) begin
    if (srst || state == rtcsr_rst) begin
      cnt_enabled <= 1'b0;
      cnt_mode <= 2'h0;
      sync_pend <= 1'b0;
    end else begin
      sync_pend <= resetting || (fld_wr && pready);
      if (!resetting) cnt_enabled <= en_p;
      if (!resetting) cnt_mode <= mode_p;
    end
  end
  // limitation: the counter only counts, no compare or period logic
  // lives here; it wraps silently at the top of its range
  // counter advances on the divided tick
  always_ff @(posedge core_clk) begin
    if (srst || state == rtcsr_rst) cnt_value <= 32'h0000_0000;
    else if (cnt_enabled && tick) cnt_value <= cnt_value + 32'h0000_0001;
  end
  // prescaler is cleared in the reset step, so the first tick after
  // a soft reset comes a full divided period later
  rtcsr_prescale u_pre (
    .core_clk(core_clk),
    .srst(srst),
    .clr(state == rtcsr_rst),
    .div_sel(div_f),
    .tick(tick)
  );
  chk_reset_ends: assert property (@(posedge core_clk) disable iff (srst)
    $rose(resetting) |-> ##[1:6] !resetting) else $error("soft reset stuck");
  chk_reset_disables: assert property (@(posedge core_clk) disable iff (srst)
    $fell(resetting) |-> !cnt_enabled && !en_p) else $error("enabled after reset");
  // the answer must be a single pulse, or a held access phase
  // would be taken twice
  // register bus answer
  chk_ready_pulse: assert property (@(posedge core_clk) disable iff (srst)
    pready |=> !pready) else $error("pready stood two cycles");
  // a control write with the trigger at zero starts nothing
  // zero trigger ignored
  chk_zero_ignored: assert property (@(posedge core_clk) disable iff (srst)
    wr_ctrl && pready && !pwdata[rtcsr_soft_reset_trigger_bit] && !resetting |=> !resetting)
    else $error("zero trigger started a reset");
  // a trigger of one starts the sequence and drops enable at once
  // trigger starts reset
  chk_trigger_starts: assert property (@(posedge core_clk) disable iff (srst)
    soft_reset_trigger_req && pready && !resetting |=> resetting && !en_p)
    else $error("trigger did not start reset");
  // fields carried with the trigger must not land
  // trigger takes priority
  chk_fields_dropped: assert property (@(posedge core_clk) disable iff (srst)
    soft_reset_trigger_req && pready |=> div_f == rtcsr_ctrl_rst[rtcsr_div_hi:rtcsr_div_lo]
    && mode_p == rtcsr_ctrl_rst[rtcsr_mode_hi:rtcsr_mode_lo])
    else $error("fields written with trigger");
  // once the trigger reads zero the pending flag is gone too
  // pending cleared at end
  chk_pend_cleared: assert property (@(posedge core_clk) disable iff (srst)
    $fell(resetting) |-> !sync_pend) else $error("pending flag left after reset");
  // readback of the trigger shows the sequencer state at capture
  // trigger readback busy
  chk_busy_readback: assert property (@(posedge core_clk) disable iff (srst)
    access && !pready && !pwrite && paddr == rtcsr_ctrl_off
    |=> prdata[rtcsr_soft_reset_trigger_bit] == $past(resetting))
    else $error("trigger readback wrong");
  // protected fields hold while the counter runs
  // fields locked when enabled
  chk_fields_locked: assert property (@(posedge core_clk) disable iff (srst)
    cnt_enabled && en_p && !(soft_reset_trigger_req && pready) && state != rtcsr_rst
    |=> $stable(div_f) && $stable(mode_p))
    else $error("protected field changed while enabled");
  // a write under protection is answered with an error
  // write protection error
  chk_protect_blocks: assert property (@(posedge core_clk) disable iff (srst)
    access && pwrite && wr_protect && !pready |=> pslverr)
    else $error("protected write not refused");
endmodule : rtcsr_top
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the counter control and soft-reset block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcsr_pkg::*;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, wr_protect = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, cnt_value, rd, mc;
  logic pready, pslverr, cnt_enabled, er;
  logic [1:0] cnt_mode;
  int n_fail = 0, checked = 0;
  always #5 core_clk = ~core_clk;
  rtcsr_top rtcsr_top_inst (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_protect(wr_protect), .cnt_enabled(cnt_enabled),
    .cnt_mode(cnt_mode), .cnt_value(cnt_value));
  // counts, verdict, end of run
  task automatic conclude();
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // one comparison against the bench model
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : cmp
  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    // a hung slave ends the run here
    if (i == 20) begin
      n_fail++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  initial begin
    int k;
    void'($urandom(32'h84b2));
    repeat (6) @(posedge core_clk);
    srst <= 0;
    apb(0, rtcsr_ctrl_off, 0);
    cmp("ctrl_rst", rtcsr_ctrl_rst, rd);
    // enable with random divider and mode, trigger bit left at zero
    mc = {20'h0_0000, 4'($urandom_range(6)), 4'h0, 2'($urandom), 2'b10};
    apb(1, rtcsr_ctrl_off, mc);
    apb(0, rtcsr_ctrl_off, 0);
    cmp("ctrl", mc, rd);
    cmp("en", 1, cnt_enabled);
    cmp("mode", mc[3:2], cnt_mode);
    // protected fields are frozen while running
    apb(1, rtcsr_ctrl_off, mc ^ 32'h0000_0F0C);
    apb(0, rtcsr_ctrl_off, 0);
    cmp("ctrl_lock", mc, rd);
    wr_protect <= 1;
    apb(1, rtcsr_ctrl_off, 0);
    cmp("wp_err", 1, er);
    wr_protect <= 0;
    apb(0, rtcsr_ctrl_off, 0);
    cmp("ctrl_wp", mc, rd);
    apb(0, 12'h010, 0);
    cmp("unmapped", 1, er);
    apb(1, rtcsr_dbg_off, 32'h0000_005A);
    // trigger while enabled, other fields must be dropped
    apb(1, rtcsr_ctrl_off, 32'h0000_0F0F);
    apb(0, rtcsr_ctrl_off, 0);
    cmp("trig_busy", 1, rd[0]);
    for (k = 0; k < 20; k++) begin
      apb(0, rtcsr_stat_off, 0);
      if (rd[0] === 1'b0) break;
    end
    cmp("sync_done", 0, rd[0]);
    apb(0, rtcsr_ctrl_off, 0);
    cmp("ctrl_after", 0, rd);
    cmp("en_after", 0, cnt_enabled);
    apb(0, rtcsr_dbg_off, 0);
    cmp("dbg_kept", 32'h0000_005A, rd);
    // ticks per divider code over the four-cycle gap between two reads
    for (k = 0; k < 3; k++) begin
      apb(1, rtcsr_ctrl_off, 32'h0000_0000);
      apb(1, rtcsr_ctrl_off, {20'h0_0000, 4'(k), 6'h00, 2'b10});
      apb(0, rtcsr_cnt_off, 0);
      mc = rd;
      apb(0, rtcsr_cnt_off, 0);
      cmp("cnt_rate", 32'(4 >> k), rd - mc);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
